/* File: src/lprt_counter.sv */
// Real-time counter core with its APB register file and interrupt.
// Assumes an APB master on clock_in and a sampled low-frequency clock.
`timescale 1ns/1ns
`default_nettype none

module lprt_counter
  import lprt_pkg::*;
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic lf_clock_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [15:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [4:0] event_out,
  output logic irq_out
);

  // Register state
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [23:0] count_r;
  logic [23:0] count_nxt;
  logic [23:0] cc_r [3];
  logic [3:0] flags_r;
  logic [3:0] flags_nxt;
  logic [4:0] sts_r;
  logic [4:0] sts_nxt;
  logic [4:0] mask_r;
  logic [4:0] event_r;
  logic irq_r;

  // Bus state
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;

  // Slow clock edge detect
  logic lf_q_r;
  logic inc;

  // Address decode for the error check; the read multiplexer decodes on its own
  function automatic logic is_mapped(input logic [15:0] a);
    is_mapped = (a == OFF_CTRL) || (a == OFF_CNT) ||
                (a == OFF_CC0) || (a == OFF_CC1) ||
                (a == OFF_CC2) || (a == OFF_FLAG) ||
                (a == OFF_ISTS) || (a == OFF_IMSK);
  endfunction

  function automatic logic [31:0] pad24(input logic [23:0] v);
    pad24 = {8'h0, v};
  endfunction

  function automatic logic [31:0] pad5(input logic [4:0] v);
    pad5 = {27'h0, v};
  endfunction

  // APB phases; one wait-free access after each setup
  wire setup = psel_in & ~penable_in & ~pready_r;
  wire access = psel_in & penable_in & pready_r;
  wire wr = access & pwrite_in & ~pslverr_r;
  wire wr_ctrl = wr & (paddr_in == OFF_CTRL);
  wire wr_cnt = wr & (paddr_in == OFF_CNT);
  wire wr_cc0 = wr & (paddr_in == OFF_CC0);
  wire wr_cc1 = wr & (paddr_in == OFF_CC1);
  wire wr_cc2 = wr & (paddr_in == OFF_CC2);
  wire wr_ists = wr & (paddr_in == OFF_ISTS);
  wire wr_imsk = wr & (paddr_in == OFF_IMSK);

  // Read multiplexer
  wire [31:0] rd_data =
    (paddr_in == OFF_CTRL) ? ctrl_r :
    (paddr_in == OFF_CNT) ? pad24(count_r) :
    (paddr_in == OFF_CC0) ? pad24(cc_r[0]) :
    (paddr_in == OFF_CC1) ? pad24(cc_r[1]) :
    (paddr_in == OFF_CC2) ? pad24(cc_r[2]) :
    (paddr_in == OFF_FLAG) ? {28'h0, flags_r} :
    (paddr_in == OFF_ISTS) ? pad5(sts_r) :
    (paddr_in == OFF_IMSK) ? pad5(mask_r) : 32'h0;

  // Slow clock is taken as synchronous, so one flop finds the edge
  wire lf_edge = lf_clock_in & ~lf_q_r;
  wire run = ctrl_r[CTRL_RUN];
  wire clr_now = ctrl_r[CTRL_CLR];
  wire key_load = wr_cnt & (pwdata_in == CNT_KEY);

  lprt_prescaler u_presc (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .lf_edge_in(lf_edge),
    .run_in(run),
    .div_in(ctrl_r[PSC_MSB:PSC_LSB]),
    .inc_out(inc)
  );

  // Clear beats key load, key load beats a step
  wire adv = inc & run & ~clr_now & ~key_load;
  wire [23:0] count_inc = count_r + 24'h1;

  assign count_nxt = clr_now ? CNT_RST :
                     key_load ? CNT_LOAD :
                     adv ? count_inc : count_r;

  // Events on the counter step
  wire ev_ovf = adv & (count_r == CNT_MAX);
  wire ev_cmp0 = adv & (count_inc == cc_r[0]);
  wire ev_cmp1 = adv & (count_inc == cc_r[1]);
  wire ev_cmp2 = adv & (count_inc == cc_r[2]);
  wire ev_tick = adv;
  wire [4:0] ev = {ev_ovf, ev_cmp2, ev_cmp1, ev_cmp0, ev_tick};

  // Prescaler frozen while running, so a stray write cannot
  // shift the rate mid count
  wire [31:0] ctrl_wr = run ?
    {pwdata_in[31:PSC_MSB+1], ctrl_r[PSC_MSB:PSC_LSB],
     pwdata_in[PSC_LSB-1:0]} : pwdata_in;

  assign ctrl_nxt = wr_ctrl ? ctrl_wr :
    {ctrl_r[31:CTRL_CLR+1], 1'b0, ctrl_r[CTRL_RUN]};

  // Flags stick until a counter clear; a clear cycle takes no step, so the clear wins
  assign flags_nxt = (clr_now ? FLAG_RST : flags_r) |
                     ev[EV_OVF:EV_CMP0];

  // Status set wins over write-one-to-clear
  assign sts_nxt = (sts_r & ~(wr_ists ? pwdata_in[4:0] : EV_RST)) |
                   (ev & ctrl_r[IEN_MSB:IEN_LSB]);

  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign event_out = event_r;
  assign irq_out = irq_r;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & ~is_mapped(paddr_in);
      prdata_r <= (setup & ~pwrite_in) ? rd_data : 32'h0;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_r <= CTRL_RST;
      count_r <= CNT_RST;
      lf_q_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      count_r <= count_nxt;
      lf_q_r <= lf_clock_in;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cc_r[0] <= CC_RST;
      cc_r[1] <= CC_RST;
      cc_r[2] <= CC_RST;
    end else begin
      if (wr_cc0) cc_r[0] <= pwdata_in[23:0];
      if (wr_cc1) cc_r[1] <= pwdata_in[23:0];
      if (wr_cc2) cc_r[2] <= pwdata_in[23:0];
    end
  end

  // Interrupt output lags the status register by one clock
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flags_r <= FLAG_RST;
      sts_r <= EV_RST;
      mask_r <= EV_RST;
      event_r <= EV_RST;
      irq_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      sts_r <= sts_nxt;
      if (wr_imsk) mask_r <= pwdata_in[4:0];
      event_r <= ev & ctrl_r[EEN_MSB:EEN_LSB];
      irq_r <= |(sts_r & mask_r);
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_clear_set;
    wr_ctrl && pwdata_in[CTRL_CLR];
  endsequence

  sequence s_clear_done;
    ctrl_r[CTRL_CLR] ##1 (!ctrl_r[CTRL_CLR] && count_r == CNT_RST);
  endsequence

  sequence s_read_count;
    setup && !pwrite_in && paddr_in == OFF_CNT;
  endsequence

  a_count_stopped: assert property (
    !run && !clr_now && !key_load |=> count_r == $past(count_r))
    else $error("counter moved while stopped");

  a_clear_pulse: assert property (
    s_clear_set |=> s_clear_done)
    else $error("clear bit did not zero the counter and drop");

  a_key_load: assert property (
    key_load && !clr_now |=> count_r == CNT_LOAD)
    else $error("key write did not load the test value");

  a_count_read: assert property (
    s_read_count |=> prdata_out == pad24($past(count_r)))
    else $error("count read returned the wrong value");

  a_cmp_store: assert property (
    wr_cc1 |=> cc_r[1] == $past(pwdata_in[23:0]))
    else $error("compare value 1 not stored");

  a_flag_hit: assert property (
    ev_cmp2 |=> flags_r[2] ##1 flags_r[2] || $past(clr_now))
    else $error("compare 2 flag not set on a hit");

  a_event_gate: assert property (
    ev_ovf && !ctrl_r[EEN_MSB] |=> !event_out[EV_OVF])
    else $error("overflow event passed while disabled");

  a_status_gate: assert property (
    $rose(sts_r[EV_TICK]) |-> $past(ctrl_r[IEN_LSB]))
    else $error("tick status set while its interrupt is off");

  a_tick_out: assert property (
    adv && ctrl_r[EEN_LSB] |=> event_out[EV_TICK] ##1 !event_out[EV_TICK]
      || $past(adv))
    else $error("tick event missing for a counter step");

  a_ovf_wrap: assert property (
    adv && count_r == CNT_MAX |=> count_r == CNT_RST && flags_r[3])
    else $error("wrap did not zero the count and set overflow");

  a_irq_level: assert property (
    sts_r[EV_OVF] && mask_r[EV_OVF] |=> irq_out)
    else $error("interrupt low with an unmasked status bit");

  a_pready_pulse: assert property (
    pready_out |=> !pready_out)
    else $error("ready stood longer than one cycle");

  a_setup_ready: assert property (
    setup |=> pready_out)
    else $error("no ready after a setup cycle");

  a_slverr_map: assert property (
    setup && !is_mapped(paddr_in) |=> pslverr_out && pready_out)
    else $error("unmapped address gave no error response");

  a_rdata_idle: assert property (
    !pready_out |-> prdata_out == 32'h0)
    else $error("read data not zero outside an access");

  a_cmp0_hit: assert property (
    ev_cmp0 |=> flags_r[0] && count_r == $past(cc_r[0]))
    else $error("compare 0 hit without a matching count");

  a_cmp1_hit: assert property (
    ev_cmp1 |=> flags_r[1] && count_r == $past(cc_r[1]))
    else $error("compare 1 hit without a matching count");

  a_flag_sticky: assert property (
    flags_r[1] && !clr_now |=> flags_r[1])
    else $error("compare 1 flag dropped without a clear");

  a_flag_clear: assert property (
    clr_now |=> flags_r == FLAG_RST)
    else $error("counter clear left a result flag set");

  a_clear_zero: assert property (
    clr_now |=> count_r == CNT_RST && !ctrl_r[CTRL_CLR])
    else $error("clear bit stood or count not zeroed");

  a_psc_frozen: assert property (
    run && wr_ctrl |=>
      ctrl_r[PSC_MSB:PSC_LSB] == $past(ctrl_r[PSC_MSB:PSC_LSB]))
    else $error("prescaler changed while running");

  a_step_one: assert property (
    adv |=> count_r == $past(count_r) + 24'h1)
    else $error("counter step was not one");

  a_key_ignore: assert property (
    wr_cnt && pwdata_in != CNT_KEY && !clr_now && !adv
    |=> count_r == $past(count_r))
    else $error("count changed on a write other than the key");

  a_cc_hold: assert property (
    !wr_cc0 |=> cc_r[0] == $past(cc_r[0]))
    else $error("compare value 0 changed without a write");

  a_ovf_event: assert property (
    ev_ovf && ctrl_r[EEN_MSB] |=> event_out[EV_OVF])
    else $error("enabled overflow event missing");

  a_cmp1_gate: assert property (
    ev_cmp1 && !ctrl_r[EEN_LSB + 2] |=> !event_out[EV_CMP0 + 1])
    else $error("compare 1 event passed while disabled");

  a_sts_set: assert property (
    ev_ovf && ctrl_r[IEN_MSB] |=> sts_r[EV_OVF])
    else $error("enabled overflow did not set its status");

  a_sts_clear: assert property (
    wr_ists && pwdata_in[EV_OVF] && !ev_ovf |=> !sts_r[EV_OVF])
    else $error("status bit not cleared by a one");

  a_tick_gate: assert property (
    ev_tick && !ctrl_r[EEN_LSB] |=> !event_out[EV_TICK])
    else $error("tick event passed while disabled");

  a_tick_status: assert property (
    ev_tick && !ctrl_r[IEN_LSB] && !sts_r[EV_TICK] |=> !sts_r[EV_TICK])
    else $error("tick status rose with its interrupt off");

  a_irq_off: assert property (
    (sts_r & mask_r) == EV_RST |=> !irq_out)
    else $error("interrupt high with no unmasked status bit");

endmodule

`default_nettype wire

/* File: src/lprt_pkg.sv */
// Constants for the low power real-time counter.
// Assumes a 20 MHz system clock and an APB register bus.
package lprt_pkg;

  // Register byte offsets, low 16 bits of the address
  localparam logic [15:0] OFF_CTRL = 16'hf024;
  localparam logic [15:0] OFF_CNT = 16'hf028;
  localparam logic [15:0] OFF_CC0 = 16'hf02c;
  localparam logic [15:0] OFF_CC1 = 16'hf030;
  localparam logic [15:0] OFF_CC2 = 16'hf034;
  localparam logic [15:0] OFF_FLAG = 16'hf038;
  localparam logic [15:0] OFF_ISTS = 16'hf03c;
  localparam logic [15:0] OFF_IMSK = 16'hf040;

  // Control field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_CLR = 1;
  localparam int PSC_LSB = 2;
  localparam int PSC_MSB = 13;
  localparam int IEN_LSB = 14;
  localparam int IEN_MSB = 18;
  localparam int EEN_LSB = 19;
  localparam int EEN_MSB = 23;

  // Event vector layout, also the interrupt status layout
  localparam int EV_TICK = 0;
  localparam int EV_CMP0 = 1;
  localparam int EV_OVF = 4;
  localparam int EV_W = 5;
  localparam int FLAG_W = 4;
  localparam int CNT_W = 24;
  localparam int PSC_W = 12;

  // Counting source and test key
  localparam int LF_FREQ_HZ = 32768;
  localparam logic [31:0] CNT_KEY = 32'h5a5aa5a5;
  localparam logic [23:0] CNT_LOAD = 24'hfffff0;
  localparam logic [23:0] CNT_MAX = 24'hffffff;

  // Values after reset
  localparam logic [31:0] CTRL_RST = 32'h0;
  localparam logic [23:0] CNT_RST = 24'h0;
  localparam logic [23:0] CC_RST = 24'h0;
  localparam logic [3:0] FLAG_RST = 4'h0;
  localparam logic [4:0] EV_RST = 5'h0;
  localparam logic [11:0] PSC_RST = 12'h0;

endpackage

/* File: src/lprt_prescaler.sv */
// Divide-by-(N+1) prescaler on low-frequency clock edges.
// Assumes the edge strobe is one system clock wide.
`timescale 1ns/1ns
`default_nettype none

module lprt_prescaler
  import lprt_pkg::*;
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic lf_edge_in,
  input wire logic run_in,
  input wire logic [11:0] div_in,
  output logic inc_out
);

  logic [11:0] div_cnt_r;
  logic [11:0] div_cnt_nxt;
  logic inc_r;
  logic inc_nxt;
  wire wrap = lf_edge_in & run_in & (div_cnt_r == div_in);

  // Stopped prescaler restarts a full period on the next run
  assign div_cnt_nxt = !run_in ? PSC_RST :
                       wrap ? PSC_RST :
                       lf_edge_in ? div_cnt_r + 12'h1 : div_cnt_r;
  assign inc_nxt = wrap;
  assign inc_out = inc_r;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_cnt_r <= PSC_RST;
      inc_r <= 1'b0;
    end else begin
      div_cnt_r <= div_cnt_nxt;
      inc_r <= inc_nxt;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  a_div_wrap: assert property (
    lf_edge_in && run_in && div_cnt_r == div_in
    |=> inc_out && div_cnt_r == PSC_RST)
    else $error("prescaler did not wrap at its divide value");

  a_div_hold: assert property (
    !run_in |=> !inc_out)
    else $error("prescaler stepped while stopped");

endmodule

`default_nettype wire

/* File: verification/lprt_counter_tb.sv */
// Self-checking bench for the real-time counter block.
// Assumes the bench is the only APB master and drives the slow clock.
`timescale 1ns/1ns
`default_nettype none

module lprt_counter_tb;
  import lprt_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic lf = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready;
  logic pslverr;
  logic e;
  logic irq;
  logic [4:0] ev;
  int fail_count = 0;
  int checks = 0;
  int evn [5] = '{0, 0, 0, 0, 0};

  lprt_counter dut (.clock_in(clk), .arst_n_in(rst_n), .lf_clock_in(lf),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwd), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .event_out(ev), .irq_out(irq));

  initial begin
    forever #25 clk = ~clk;
  end

  // Event pulses last one clock, so count them on every edge
  always @(posedge clk) begin
    for (int i = 0; i < 5; i++) if (ev[i] === 1'b1) evn[i]++;
  end

  task end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      fail_count++;
    end
  endtask

  // Holds the request until pready is seen high; no fixed latency assumed
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk(32'h0, 32'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask

  task rd(input logic [15:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask

  task wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Slow clock only as fast as the sampler can follow
  task lfp(input int n);
    repeat (n) begin
      lf <= 1'b1;
      repeat (3) @(posedge clk);
      lf <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask

  task irq_is(input logic x);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, {31'h0, x});
  endtask

  task t_reset;
    for (int i = 0; i < 8; i++) rd(OFF_CTRL + 16'(4 * i), 32'h0);
    apb(1'b0, 16'hf044, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(OFF_CC0 + 16'(4 * i), 32'h00abcde0 + 32'(i));
      rd(OFF_CC0 + 16'(4 * i), 32'h00abcde0 + 32'(i));
    end
    wr(OFF_FLAG, 32'hf);
    rd(OFF_FLAG, 32'h0);
  endtask

  task t_overflow;
    wr(OFF_CC0, 32'h00fffff4);
    wr(OFF_CC1, 32'h00000002);
    wr(OFF_CC2, 32'h00fffff8);
    wr(OFF_CNT, CNT_KEY);
    rd(OFF_CNT, 32'h00fffff0);
    wr(OFF_CNT, 32'h00000123);
    rd(OFF_CNT, 32'h00fffff0);
    // All event enables, interrupts for overflow and compare 0, run
    wr(OFF_CTRL, 32'h00fc8001);
    lfp(15);
    rd(OFF_CNT, 32'h00ffffff);
    lfp(1);
    rd(OFF_CNT, 32'h0);
    rd(OFF_FLAG, 32'hd);
    rd(OFF_ISTS, 32'h12);
    chk(32'({4'(evn[4]), 4'(evn[3]), 4'(evn[2]), 4'(evn[1]), 8'(evn[0])}),
      32'h110110);
    wr(OFF_IMSK, 32'h2);
    irq_is(1'b1);
    wr(OFF_ISTS, 32'h2);
    irq_is(1'b0);
    rd(OFF_ISTS, 32'h10);
    wr(OFF_IMSK, 32'h10);
    irq_is(1'b1);
    wr(OFF_ISTS, 32'h10);
    irq_is(1'b0);
  endtask

  task t_prescale;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CTRL, 32'h8);
    wr(OFF_CTRL, 32'h9);
    lfp(6);
    rd(OFF_CNT, 32'h2);
    rd(OFF_FLAG, 32'hf);
    wr(OFF_CTRL, 32'h1);
    rd(OFF_CTRL, 32'h9);
    lfp(3);
    rd(OFF_CNT, 32'h3);
  endtask

  task t_clear;
    wr(OFF_CTRL, 32'hb);
    rd(OFF_CTRL, 32'h9);
    rd(OFF_CNT, 32'h0);
    rd(OFF_FLAG, 32'h0);
    // Event enables were off since the prescale run
    chk(32'({4'(evn[4]), 4'(evn[3]), 4'(evn[2]), 4'(evn[1]), 8'(evn[0])}),
      32'h110110);
  endtask

  // Mid-run reset must bring every register back to zero
  task t_rerst;
    wr(OFF_CNT, CNT_KEY);
    wr(OFF_IMSK, 32'h1f);
    rd(OFF_CNT, 32'h00fffff0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd(OFF_CTRL + 16'(4 * i), 32'h0);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_overflow;
    t_prescale;
    t_clear;
    t_rerst;
    end_sim;
  end

  // Whole run takes a few hundred clocks
  initial begin
    #2000000;
    fail_count++;
    end_sim;
  end
endmodule

`default_nettype wire
